// *** hdl/sensor_frame_defines.vh ***
// Register offsets, field positions, reset values and row formats of the frame logic
`ifndef SENSOR_FRAME_DEFINES_VH
`define SENSOR_FRAME_DEFINES_VH
// Register offsets of context A, context B and shared registers
`define OFS_ROW_FIRST_A 16'h3002
`define OFS_COL_FIRST_A 16'h3004
`define OFS_ROW_LAST_A 16'h3006
`define OFS_COL_LAST_A 16'h3008
`define OFS_ROWS_FRAME_A 16'h300a
`define OFS_CLKS_ROW_A 16'h300c
`define OFS_EXPOSURE_A 16'h3012
`define OFS_EXPOSURE_B 16'h3016
`define OFS_FRAME_COUNTER 16'h303a
`define OFS_CLKS_ROW_B 16'h303e
`define OFS_BINNING 16'h3040
`define OFS_GREEN1_A 16'h3056
`define OFS_BLUE_A 16'h3058
`define OFS_RED_A 16'h305a
`define OFS_GREEN2_A 16'h305c
`define OFS_OVERALL_A 16'h305e
`define OFS_ANALOG_GAIN 16'h3060
`define OFS_EMB_CONTROL 16'h3064
`define OFS_OPCTRL_A 16'h3082
`define OFS_OPCTRL_B 16'h3084
`define OFS_COL_FIRST_B 16'h308a
`define OFS_ROW_FIRST_B 16'h308c
`define OFS_COL_LAST_B 16'h308e
`define OFS_ROW_LAST_B 16'h3090
`define OFS_COL_SKIP_A 16'h30a2
`define OFS_ROW_SKIP_A 16'h30a6
`define OFS_ROW_SKIP_B 16'h30a8
`define OFS_ROWS_FRAME_B 16'h30aa
`define OFS_COL_SKIP_B 16'h30ae
`define OFS_CONTEXT_CTRL 16'h30b0
`define OFS_TEMP_RESULT 16'h30b2
`define OFS_TEMP_CTRL 16'h30b4
`define OFS_SEQ_CTRL 16'h30ba
`define OFS_GREEN1_B 16'h30bc
`define OFS_BLUE_B 16'h30be
`define OFS_RED_B 16'h30c0
`define OFS_GREEN2_B 16'h30c2
`define OFS_OVERALL_B 16'h30c4
`define OFS_CALIB_HOT 16'h30c6
`define OFS_CALIB_WARM 16'h30c8
`define OFS_PIX_BYPASS 16'h318e
`define OFS_COMPAND_EN 16'h31d0
`define OFS_FRAME_IDENTIFIER 16'h31d2
// Field positions
`define BIT_CONTEXT_SEL 13
`define BIT_TEMP_EN0 0
`define BIT_TEMP_EN1 4
`define BIT_SINGLE_SEQ 8
`define BIT_EMB_DATA 8
`define BIT_EMB_STATS 7
`define BIT_OPM_HDR 0
`define BIT_ROW_BIN_A 12
`define BIT_COL_BIN_A 13
`define BIT_ROW_BIN_B 10
`define BIT_COL_BIN_B 11
// Reset values
`define RST_EMB_CONTROL 16'h0100
`define RST_REG 16'h0000
// Embedded row layout
`define EMB_ROW1_FIRST 16'h3000
`define EMB_ROW2_FIRST 16'h3136
`define EMB_ROW2_SECOND 16'h31d0
`define EMB_ROW1_LEN 9'd304
`define EMB_ROW2_LEN 9'd186
`define EMB_ROW2_SPLIT 8'd69
`define STAT_ROW1_LEN 9'd247
`define STAT_ROW2_LEN 9'd7
`define HIST_BINS 8'd244
`define STAT_TAG 12'h0b0
`endif

// *** hdl/sensor_context_and_embedded_rows.v ***
// Frame-delayed register contexts, companding and embedded row formatter
`timescale 1ns/1ps
`include "sensor_frame_defines.vh"

module sensor_context_and_embedded_rows #(
	parameter NSLOT = 39
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] rd_data,
	output reg rd_valid,
	input wire [9:0] temp_adc_value,
	input wire [15:0] calib_hot_value,
	input wire [15:0] calib_warm_value,
	output wire temp_sense_enable,
	input wire frame_start,
	input wire frame_end,
	output wire src_ready,
	input wire pix_valid,
	input wire [11:0] pix_data,
	input wire pix_line_end,
	input wire pix_first_exposure,
	output wire [7:0] stat_sel,
	input wire [9:0] stat_value,
	output reg out_valid,
	output reg [11:0] out_data,
	output reg out_line_end,
	output wire context_active,
	output wire [15:0] cfg_exposure_rows,
	output wire [15:0] cfg_rows_per_frame,
	output wire [15:0] cfg_clocks_per_row,
	output wire [15:0] cfg_row_first,
	output wire [15:0] cfg_row_last,
	output wire [15:0] cfg_col_first,
	output wire [15:0] cfg_col_last,
	output wire [15:0] cfg_row_skip,
	output wire [15:0] cfg_col_skip,
	output wire cfg_row_bin,
	output wire cfg_col_bin,
	output wire [3:0] cfg_fine_gain,
	output wire [1:0] cfg_coarse_gain,
	output wire [15:0] cfg_first_green_gain_a,
	output wire [15:0] cfg_blue_gain,
	output wire [15:0] cfg_red_gain,
	output wire [15:0] cfg_second_green_gain_a,
	output wire [15:0] cfg_overall_gain,
	output wire [15:0] cfg_operating_control,
	output wire [1:0] cfg_pixel_combine_bypass,
	output wire single_sequencer_mode,
	output reg seq_reload_req
);

	localparam ST_IDLE = 2'd0;
	localparam ST_TOP = 2'd1;
	localparam ST_IMAGE = 2'd2;
	localparam ST_BOTTOM = 2'd3;
	localparam [5:0] NO_SLOT = 6'h3f;

	reg [15:0] live_mem [0:NSLOT-1];
	reg [15:0] pend_mem [0:NSLOT-1];
	reg [15:0] act_mem [0:NSLOT-1];
	reg ctx_exp_reg;
	reg ctx_cfg_reg;
	reg hdr_prev_reg;
	reg [15:0] frame_cnt_reg;
	reg [9:0] temp_reg;
	reg [1:0] state_reg;
	reg row_reg;
	reg [8:0] idx_reg;
	reg [15:0] emb_word;
	reg [8:0] row_len;
	reg [11:0] fmt_pix;
	integer i;

	// Address to storage slot of every writable register
	function [5:0] slot_of;
		input [15:0] a;
		begin
			case (a)
				`OFS_ROW_FIRST_A: slot_of = 6'd0;
				`OFS_COL_FIRST_A: slot_of = 6'd1;
				`OFS_ROW_LAST_A: slot_of = 6'd2;
				`OFS_COL_LAST_A: slot_of = 6'd3;
				`OFS_ROWS_FRAME_A: slot_of = 6'd4;
				`OFS_CLKS_ROW_A: slot_of = 6'd5;
				`OFS_EXPOSURE_A: slot_of = 6'd6;
				`OFS_EXPOSURE_B: slot_of = 6'd7;
				`OFS_CLKS_ROW_B: slot_of = 6'd8;
				`OFS_BINNING: slot_of = 6'd9;
				`OFS_GREEN1_A: slot_of = 6'd10;
				`OFS_BLUE_A: slot_of = 6'd11;
				`OFS_RED_A: slot_of = 6'd12;
				`OFS_GREEN2_A: slot_of = 6'd13;
				`OFS_OVERALL_A: slot_of = 6'd14;
				`OFS_ANALOG_GAIN: slot_of = 6'd15;
				`OFS_EMB_CONTROL: slot_of = 6'd16;
				`OFS_OPCTRL_A: slot_of = 6'd17;
				`OFS_OPCTRL_B: slot_of = 6'd18;
				`OFS_COL_FIRST_B: slot_of = 6'd19;
				`OFS_ROW_FIRST_B: slot_of = 6'd20;
				`OFS_COL_LAST_B: slot_of = 6'd21;
				`OFS_ROW_LAST_B: slot_of = 6'd22;
				`OFS_COL_SKIP_A: slot_of = 6'd23;
				`OFS_ROW_SKIP_A: slot_of = 6'd24;
				`OFS_ROW_SKIP_B: slot_of = 6'd25;
				`OFS_ROWS_FRAME_B: slot_of = 6'd26;
				`OFS_COL_SKIP_B: slot_of = 6'd27;
				`OFS_CONTEXT_CTRL: slot_of = 6'd28;
				`OFS_TEMP_CTRL: slot_of = 6'd29;
				`OFS_SEQ_CTRL: slot_of = 6'd30;
				`OFS_GREEN1_B: slot_of = 6'd31;
				`OFS_BLUE_B: slot_of = 6'd32;
				`OFS_RED_B: slot_of = 6'd33;
				`OFS_GREEN2_B: slot_of = 6'd34;
				`OFS_OVERALL_B: slot_of = 6'd35;
				`OFS_PIX_BYPASS: slot_of = 6'd36;
				`OFS_COMPAND_EN: slot_of = 6'd37;
				`OFS_FRAME_IDENTIFIER: slot_of = 6'd38;
				default: slot_of = NO_SLOT;
			endcase
		end
	endfunction

	// Value of an address, from live or frame-active storage
	function [15:0] reg_image;
		input [15:0] a;
		input use_act;
		reg [5:0] s;
		begin
			s = slot_of(a);
			case (a)
				`OFS_FRAME_COUNTER: reg_image = frame_cnt_reg;
				`OFS_TEMP_RESULT: reg_image = {6'h00, temp_reg};
				`OFS_CALIB_HOT: reg_image = calib_hot_value;
				`OFS_CALIB_WARM: reg_image = calib_warm_value;
				default: begin
					if (s == NO_SLOT)
						reg_image = 16'h0000;
					else if (use_act)
						reg_image = act_mem[s];
					else
						reg_image = live_mem[s];
				end
			endcase
		end
	endfunction

	// Frame-active value of a writable register
	function [15:0] act;
		input [15:0] a;
		begin
			act = act_mem[slot_of(a)];
		end
	endfunction

	// Piecewise 12-to-10 bit code
	function [9:0] compand;
		input [11:0] x;
		begin
			if (x[11])
				compand = {2'b11, x[10:3]};
			else if (x[10])
				compand = {2'b10, x[9:2]};
			else if (x[9])
				compand = {3'b011, x[8:2]};
			else if (x[8])
				compand = {3'b010, x[7:1]};
			else
				compand = {2'b00, x[7:0]};
		end
	endfunction

	wire frame_take = frame_start && (state_reg == ST_IDLE);
	wire [5:0] wr_slot = slot_of(reg_addr);
	wire ctx_live = live_mem[slot_of(`OFS_CONTEXT_CTRL)][`BIT_CONTEXT_SEL];
	wire [15:0] emb_ctrl = act(`OFS_EMB_CONTROL);
	wire [15:0] opctrl = ctx_cfg_reg ? act(`OFS_OPCTRL_B) : act(`OFS_OPCTRL_A);
	wire hdr_mode = opctrl[`BIT_OPM_HDR];
	wire compand_on = act(`OFS_COMPAND_EN) == 16'h0001;
	wire drop_pix = single_sequencer_mode && !hdr_mode && !pix_first_exposure;
	wire [15:0] gain_an = act(`OFS_ANALOG_GAIN);
	wire [15:0] binning = act(`OFS_BINNING);
	wire [15:0] bypass = act(`OFS_PIX_BYPASS);
	wire [15:0] temp_ctrl = live_mem[slot_of(`OFS_TEMP_CTRL)];
	wire [7:0] reg_k = idx_reg[8:1];
	wire [15:0] seq_ctrl = act(`OFS_SEQ_CTRL);
	wire [15:0] frame_ident = act(`OFS_FRAME_IDENTIFIER);

	// Staged register storage, written live, copied at frame start
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < NSLOT; i = i + 1) begin
				live_mem[i] <= (i == 16) ? `RST_EMB_CONTROL : `RST_REG;
				pend_mem[i] <= (i == 16) ? `RST_EMB_CONTROL : `RST_REG;
				act_mem[i] <= (i == 16) ? `RST_EMB_CONTROL : `RST_REG;
			end
		end else if (ce) begin
			if (reg_wr && wr_slot != NO_SLOT)
				live_mem[wr_slot] <= reg_wdata;
			if (frame_take) begin
				for (i = 0; i < NSLOT; i = i + 1) begin
					pend_mem[i] <= live_mem[i];
					act_mem[i] <= pend_mem[i];
				end
			end
		end
	end

	// Context staging, sequencer reload and frame counter
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctx_exp_reg <= 1'b0;
			ctx_cfg_reg <= 1'b0;
			hdr_prev_reg <= 1'b0;
			seq_reload_req <= 1'b0;
			frame_cnt_reg <= 16'h0000;
		end else if (ce) begin
			seq_reload_req <= 1'b0;
			if (frame_take) begin
				ctx_exp_reg <= ctx_live;
				ctx_cfg_reg <= ctx_exp_reg;
				frame_cnt_reg <= frame_cnt_reg + 16'h0001;
			end
			hdr_prev_reg <= hdr_mode;
			if (hdr_prev_reg != hdr_mode && !single_sequencer_mode)
				seq_reload_req <= 1'b1;
		end
	end

	// Register read port and temperature capture
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			temp_reg <= 10'h000;
		end else if (ce) begin
			rd_valid <= reg_rd;
			if (reg_rd)
				rd_data <= reg_image(reg_addr, 1'b0);
			if (temp_sense_enable)
				temp_reg <= temp_adc_value;
		end
	end

	assign temp_sense_enable = temp_ctrl[`BIT_TEMP_EN0] && temp_ctrl[`BIT_TEMP_EN1];

	// Context configuration: exposure rows from ctx_exp_reg, the rest from the active context
	assign context_active = ctx_cfg_reg;
	assign cfg_exposure_rows = ctx_exp_reg ? act(`OFS_EXPOSURE_B) : act(`OFS_EXPOSURE_A);
	assign cfg_rows_per_frame = ctx_cfg_reg ? act(`OFS_ROWS_FRAME_B) : act(`OFS_ROWS_FRAME_A);
	assign cfg_clocks_per_row = ctx_cfg_reg ? act(`OFS_CLKS_ROW_B) : act(`OFS_CLKS_ROW_A);
	assign cfg_row_first = ctx_cfg_reg ? act(`OFS_ROW_FIRST_B) : act(`OFS_ROW_FIRST_A);
	assign cfg_row_last = ctx_cfg_reg ? act(`OFS_ROW_LAST_B) : act(`OFS_ROW_LAST_A);
	assign cfg_col_first = ctx_cfg_reg ? act(`OFS_COL_FIRST_B) : act(`OFS_COL_FIRST_A);
	assign cfg_col_last = ctx_cfg_reg ? act(`OFS_COL_LAST_B) : act(`OFS_COL_LAST_A);
	assign cfg_row_skip = ctx_cfg_reg ? act(`OFS_ROW_SKIP_B) : act(`OFS_ROW_SKIP_A);
	assign cfg_col_skip = ctx_cfg_reg ? act(`OFS_COL_SKIP_B) : act(`OFS_COL_SKIP_A);
	assign cfg_row_bin = ctx_cfg_reg ? binning[`BIT_ROW_BIN_B] : binning[`BIT_ROW_BIN_A];
	assign cfg_col_bin = ctx_cfg_reg ? binning[`BIT_COL_BIN_B] : binning[`BIT_COL_BIN_A];
	assign cfg_fine_gain = ctx_cfg_reg ? gain_an[11:8] : gain_an[3:0];
	assign cfg_coarse_gain = ctx_cfg_reg ? gain_an[13:12] : gain_an[5:4];
	assign cfg_first_green_gain_a = ctx_cfg_reg ? act(`OFS_GREEN1_B) : act(`OFS_GREEN1_A);
	assign cfg_blue_gain = ctx_cfg_reg ? act(`OFS_BLUE_B) : act(`OFS_BLUE_A);
	assign cfg_red_gain = ctx_cfg_reg ? act(`OFS_RED_B) : act(`OFS_RED_A);
	assign cfg_second_green_gain_a = ctx_cfg_reg ? act(`OFS_GREEN2_B) : act(`OFS_GREEN2_A);
	assign cfg_overall_gain = ctx_cfg_reg ? act(`OFS_OVERALL_B) : act(`OFS_OVERALL_A);
	assign cfg_operating_control = opctrl;
	assign cfg_pixel_combine_bypass = ctx_cfg_reg ? bypass[15:14] : bypass[13:12];
	assign single_sequencer_mode = seq_ctrl[`BIT_SINGLE_SEQ];

	// Source may only send image pixels during the image phase
	assign src_ready = (state_reg == ST_IMAGE);

	// Statistics engine index: bins, then six summary values
	assign stat_sel = row_reg ? (`HIST_BINS + idx_reg[7:0] - 8'd1) : (idx_reg[7:0] - 8'd3);

	// Embedded row word, length and pixel selection
	always @* begin
		emb_word = 16'h0000;
		row_len = `EMB_ROW1_LEN;
		fmt_pix = 12'h000;
		if (state_reg == ST_TOP) begin
			if (!row_reg)
				emb_word = reg_image(`EMB_ROW1_FIRST + {7'h00, reg_k, 1'b0}, 1'b1);
			else if (reg_k < `EMB_ROW2_SPLIT)
				emb_word = reg_image(`EMB_ROW2_FIRST + {7'h00, reg_k, 1'b0}, 1'b1);
			else
				emb_word = reg_image(`EMB_ROW2_SECOND +
					{7'h00, reg_k - `EMB_ROW2_SPLIT, 1'b0}, 1'b1);
			row_len = row_reg ? `EMB_ROW2_LEN : `EMB_ROW1_LEN;
			if (emb_ctrl[`BIT_EMB_DATA])
				fmt_pix = idx_reg[0] ? {emb_word[7:0], 4'h0} : {emb_word[15:8], 4'h0};
			else
				fmt_pix = 12'h000;
		end else begin
			row_len = row_reg ? `STAT_ROW2_LEN : `STAT_ROW1_LEN;
			if (idx_reg == 9'd0)
				fmt_pix = `STAT_TAG;
			else if (row_reg)
				fmt_pix = {stat_value, 2'b00};
			else if (idx_reg == 9'd1)
				fmt_pix = {frame_cnt_reg[9:0], 2'b00};
			else if (idx_reg == 9'd2)
				fmt_pix = {frame_ident[9:0], 2'b00};
			else
				fmt_pix = {stat_value, 2'b00};
		end
	end

	// Frame sequencing and output stream
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			row_reg <= 1'b0;
			idx_reg <= 9'd0;
			out_valid <= 1'b0;
			out_data <= 12'h000;
			out_line_end <= 1'b0;
		end else if (ce) begin
			out_valid <= 1'b0;
			out_line_end <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					row_reg <= 1'b0;
					idx_reg <= 9'd0;
					if (frame_take)
						state_reg <= ST_TOP;
				end
				ST_TOP, ST_BOTTOM: begin
					out_valid <= 1'b1;
					out_data <= fmt_pix;
					idx_reg <= idx_reg + 9'd1;
					if (idx_reg == row_len - 9'd1) begin
						out_line_end <= 1'b1;
						idx_reg <= 9'd0;
						row_reg <= ~row_reg;
						if (row_reg)
							state_reg <= (state_reg == ST_TOP) ? ST_IMAGE : ST_IDLE;
					end
				end
				ST_IMAGE: begin
					if (pix_valid && !drop_pix) begin
						out_valid <= 1'b1;
						out_line_end <= pix_line_end;
						if (compand_on && !hdr_mode)
							out_data <= {2'b00, compand(pix_data)};
						else
							out_data <= pix_data;
					end
					if (frame_end) begin
						row_reg <= 1'b0;
						idx_reg <= 9'd0;
						state_reg <= emb_ctrl[`BIT_EMB_STATS] ? ST_BOTTOM : ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

// *** testbench/sensor_frame_chk.sv ***
// Port checks on the frame logic
`timescale 1ns/1ps
`include "sensor_frame_defines.vh"
module sensor_frame_chk (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_addr,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire [15:0] calib_hot_value,
	input wire temp_sense_enable,
	input wire frame_start,
	input wire src_ready,
	input wire pix_valid,
	input wire [11:0] pix_data,
	input wire pix_first_exposure,
	input wire out_valid,
	input wire [11:0] out_data,
	input wire context_active,
	input wire [15:0] cfg_exposure_rows,
	input wire [15:0] cfg_rows_per_frame,
	input wire [15:0] cfg_operating_control,
	input wire single_sequencer_mode,
	input wire seq_reload_req
);
	reg temp_wr_q;
	default clocking chk_clk @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Temperature control write seen one cycle back
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			temp_wr_q <= 1'b0;
		end else begin
			temp_wr_q <= ce && reg_wr && (reg_addr == `OFS_TEMP_CTRL);
		end
	end
	// Image pixels that must reach the output, and those that must not
	sequence img_take;
		ce && src_ready && pix_valid && (!single_sequencer_mode || pix_first_exposure
			|| cfg_operating_control[`BIT_OPM_HDR]);
	endsequence
	sequence img_drop;
		ce && src_ready && pix_valid && single_sequencer_mode && !pix_first_exposure
			&& !cfg_operating_control[`BIT_OPM_HDR];
	endsequence
	a_read_answer: assert property (ce && reg_rd |=> rd_valid)
		else $error("read strobe not answered");
	a_read_single: assert property (ce && !reg_rd |=> !rd_valid)
		else $error("read answer without strobe");
	a_calib_read: assert property (ce && reg_rd && reg_addr == `OFS_CALIB_HOT
		|=> rd_data == $past(calib_hot_value))
		else $error("hot calibration word wrong");
	a_temp_cause: assert property ($changed(temp_sense_enable) |-> temp_wr_q)
		else $error("temperature enable moved without a write");
	a_pixel_out: assert property (img_take |=> out_valid)
		else $error("image pixel lost");
	a_pixel_low: assert property (img_take ##0 (pix_data < 12'h100)
		|=> out_data == $past(pix_data))
		else $error("low pixel code altered");
	a_pixel_drop: assert property (img_drop |=> !out_valid)
		else $error("second exposure pixel sent");
	a_ctx_frame: assert property ($changed(context_active) |-> $past(frame_start))
		else $error("context moved off a frame boundary");
	a_cfg_frame: assert property ($changed({cfg_exposure_rows, cfg_rows_per_frame})
		|-> $past(frame_start))
		else $error("settings moved off a frame boundary");
	a_no_reload: assert property (single_sequencer_mode |-> !seq_reload_req)
		else $error("reload asked in single sequencer mode");
	a_reload_pulse: assert property (seq_reload_req |=> !seq_reload_req)
		else $error("reload request too long");
	a_reload_cause: assert property (ce && !single_sequencer_mode
		&& $changed(cfg_operating_control[`BIT_OPM_HDR]) |=> seq_reload_req)
		else $error("mode change without sequencer reload");
	c_drop: cover property (img_drop);
endmodule

bind sensor_context_and_embedded_rows sensor_frame_chk chk_u (.mclk(mclk), .rst_n(rst_n),
	.ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .rd_data(rd_data),
	.rd_valid(rd_valid), .calib_hot_value(calib_hot_value), .frame_start(frame_start),
	.temp_sense_enable(temp_sense_enable), .src_ready(src_ready), .pix_valid(pix_valid),
	.pix_data(pix_data), .pix_first_exposure(pix_first_exposure), .out_valid(out_valid),
	.out_data(out_data), .context_active(context_active),
	.cfg_exposure_rows(cfg_exposure_rows), .cfg_rows_per_frame(cfg_rows_per_frame),
	.cfg_operating_control(cfg_operating_control),
	.single_sequencer_mode(single_sequencer_mode), .seq_reload_req(seq_reload_req));

// *** testbench/stat_engine_model.sv ***
// Statistics engine and downstream row counter
`timescale 1ns/1ps
module stat_engine_model (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] stat_sel,
	output wire [9:0] stat_value,
	input wire out_valid,
	input wire out_line_end,
	output reg [15:0] row_count
);
	// Same-cycle answer tied to the index
	assign stat_value = {2'b10, stat_sel} ^ 10'h0a5;
	// Rows received downstream
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			row_count <= 16'h0000;
		end else if (out_valid && out_line_end) begin
			row_count <= row_count + 16'h0001;
		end
	end
endmodule

// *** testbench/sensor_context_and_embedded_rows_tb.sv ***
// Self-checking bench for the frame logic
`timescale 1ns/1ps
`include "sensor_frame_defines.vh"
module sensor_context_and_embedded_rows_tb;
	reg mclk, rst_n, reg_wr, reg_rd, frame_start, frame_end, pix_valid, pix_line_end;
	reg pix_first_exposure, ctx_exp, ctx_cfg, ce;
	reg [15:0] reg_addr, reg_wdata, calib_hot_value, calib_warm_value;
	reg [9:0] temp_adc_value;
	reg [11:0] pix_data;
	wire [15:0] rd_data, cfg_exposure_rows, cfg_rows_per_frame, cfg_operating_control, row_count;
	wire [3:0] cfg_fine_gain;
	wire [1:0] cfg_coarse_gain;
	wire [7:0] stat_sel;
	wire [9:0] stat_value;
	wire [11:0] out_data;
	wire rd_valid, temp_sense_enable, src_ready, out_valid, out_line_end, context_active;
	wire single_sequencer_mode, seq_reload_req;
	integer bad_count = 0, n_checks = 0, rows_exp = 0, n_frm = 0, i, k;
	reg [15:0] live [0:255], pend [0:255], act [0:255];
	reg [24:0] pq [$];
	reg [31:0] rq [$];
	reg [31:0] re;
	reg [24:0] pe;
	reg [119:0] edg = {12'h000, 12'h0ff, 12'h100, 12'h1ff, 12'h200, 12'h3ff, 12'h400,
		12'h7ff, 12'h800, 12'hfff};
	reg [255:0] rw_list = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0b, 8'h1f,
		8'h20, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h45, 8'h46, 8'h47, 8'h48, 8'h51,
		8'h53, 8'h54, 8'h55, 8'h57, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'hc7, 8'he9};

	sensor_context_and_embedded_rows dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.rd_data(rd_data), .rd_valid(rd_valid), .temp_adc_value(temp_adc_value),
		.calib_hot_value(calib_hot_value), .calib_warm_value(calib_warm_value),
		.temp_sense_enable(temp_sense_enable), .frame_start(frame_start),
		.frame_end(frame_end), .src_ready(src_ready), .pix_valid(pix_valid),
		.pix_data(pix_data), .pix_line_end(pix_line_end),
		.pix_first_exposure(pix_first_exposure), .stat_sel(stat_sel),
		.stat_value(stat_value), .out_valid(out_valid), .out_data(out_data),
		.out_line_end(out_line_end), .context_active(context_active),
		.cfg_exposure_rows(cfg_exposure_rows), .cfg_rows_per_frame(cfg_rows_per_frame),
		.cfg_clocks_per_row(), .cfg_row_first(), .cfg_row_last(), .cfg_col_first(),
		.cfg_col_last(), .cfg_row_skip(), .cfg_col_skip(), .cfg_row_bin(), .cfg_col_bin(),
		.cfg_fine_gain(cfg_fine_gain), .cfg_coarse_gain(cfg_coarse_gain), .cfg_first_green_gain_a(),
		.cfg_blue_gain(), .cfg_red_gain(), .cfg_second_green_gain_a(), .cfg_overall_gain(),
		.cfg_operating_control(cfg_operating_control), .cfg_pixel_combine_bypass(),
		.single_sequencer_mode(single_sequencer_mode), .seq_reload_req(seq_reload_req));
	stat_engine_model far_u (.mclk(mclk), .rst_n(rst_n), .stat_sel(stat_sel),
		.stat_value(stat_value), .out_valid(out_valid), .out_line_end(out_line_end),
		.row_count(row_count));

	task cmp_val(input [15:0] got, input [15:0] exp, input [15:0] m);
		n_checks = n_checks + 1;
		if ((got & m) !== (exp & m)) begin
			bad_count = bad_count + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_pix(input [24:0] e);
		cmp_val({3'h0, out_line_end, out_data}, {3'h0, e[24], e[11:0]}, {4'h1, e[23:12]});
	endtask
	task wr(input [15:0] a, input [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a[15:9] == 7'h18 && a != `OFS_CALIB_HOT) live[a[8:1]] = d;
	endtask
	task rd(input [15:0] a, input [15:0] e, input [15:0] m);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		rq.push_back({m, e});
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask
	function [11:0] cmpd(input [11:0] x);
		if (x < 12'h100) cmpd = x;
		else if (x < 12'h200) cmpd = {5'h02, x[7:1]};
		else if (x < 12'h400) cmpd = {5'h03, x[8:2]};
		else if (x < 12'h800) cmpd = {4'h2, x[9:2]};
		else cmpd = {4'h3, x[10:3]};
	endfunction
	// One frame: boundary model, top rows, image, statistics
	task frame(input integer rows);
		reg [15:0] v;
		reg [11:0] m, x;
		reg [31:0] rnd;
		reg hdr, fe;
		integer r, c, a, w;
		n_frm = n_frm + 1;
		for (a = 0; a < 256; a = a + 1) begin
			act[a] = pend[a];
			pend[a] = live[a];
		end
		ctx_cfg = ctx_exp;
		ctx_exp = live[8'h58][`BIT_CONTEXT_SEL];
		for (a = 0; a < 256; a = a + 1) begin
			if (a < 152 || (a >= 8'h9b && a <= 8'hdf) || a >= 8'he8) begin
				v = act[8'h32][`BIT_EMB_DATA] ? act[a] : 16'h0000;
				m = (act[8'h32][`BIT_EMB_DATA] && (a == 8'h1d || (a >= 8'h58 && a <= 8'h5a)
					|| a == 8'h63 || a == 8'h64)) ? 12'h000 : 12'hfff;
				pq.push_back({1'b0, m, v[15:8], 4'h0});
				pq.push_back({a == 151 || a == 255, m, v[7:0], 4'h0});
			end
		end
		@(posedge mclk);
		frame_start <= 1'b1;
		@(posedge mclk);
		frame_start <= 1'b0;
		w = 0;
		while (src_ready !== 1'b1 && w < 1000) begin
			@(negedge mclk);
			w = w + 1;
		end
		cmp_val({15'h0, context_active}, {15'h0, ctx_cfg}, 16'hffff);
		cmp_val(cfg_exposure_rows, act[ctx_exp ? 8'h0b : 8'h09], 16'hffff);
		cmp_val(cfg_rows_per_frame, act[ctx_cfg ? 8'h55 : 8'h05], 16'hffff);
		v = act[8'h30];
		cmp_val({10'h0, cfg_coarse_gain, cfg_fine_gain},
			{10'h0, ctx_cfg ? v[13:8] : v[5:0]}, 16'hffff);
		hdr = act[ctx_cfg ? 8'h42 : 8'h41][`BIT_OPM_HDR];
		for (r = 0; r < rows; r = r + 1) begin
			for (c = 0; c < 12; c = c + 1) begin
				@(posedge mclk);
				rnd = $urandom;
				x = (r == 0 && c < 10) ? edg[12 * (9 - c) +: 12] : rnd[11:0];
				fe = rnd[12] | (c == 11);
				pix_valid <= 1'b1;
				pix_data <= x;
				pix_line_end <= (c == 11);
				pix_first_exposure <= fe;
				if (!act[8'h5d][`BIT_SINGLE_SEQ] || fe || hdr)
					pq.push_back({c == 11, 12'hfff, (!hdr && act[8'he8] == 16'h0001)
						? cmpd(x) : x});
			end
		end
		@(posedge mclk);
		pix_valid <= 1'b0;
		pix_line_end <= 1'b0;
		frame_end <= 1'b1;
		if (act[8'h32][`BIT_EMB_STATS]) begin
			v = act[8'he9];
			pq.push_back({1'b0, 12'hfff, `STAT_TAG});
			pq.push_back({1'b0, 12'hfff, n_frm[9:0], 2'b00});
			pq.push_back({1'b0, 12'hfff, v[9:0], 2'b00});
			for (c = 0; c < 250; c = c + 1) begin
				if (c == 244) pq.push_back({1'b0, 12'hfff, `STAT_TAG});
				pq.push_back({c == 243 || c == 249, 12'hfff,
					{2'b10, c[7:0]} ^ 10'h0a5, 2'b00});
			end
		end
		rows_exp = rows_exp + 2 + rows + (act[8'h32][`BIT_EMB_STATS] ? 2 : 0);
		@(posedge mclk);
		frame_end <= 1'b0;
		w = 0;
		while (pq.size() != 0 && w < 2000) begin
			@(negedge mclk);
			w = w + 1;
		end
		repeat (3) @(posedge mclk);
	endtask
	task finish_test;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Result watcher: oldest note against each answer and pixel
	always @(negedge mclk) begin
		if (rd_valid === 1'b1) begin
			if (rq.size() == 0) cmp_val(16'h0001, 16'h0000, 16'hffff);
			else begin
				re = rq.pop_front();
				cmp_val(rd_data, re[15:0], re[31:16]);
			end
		end
		if (out_valid === 1'b1) begin
			if (pq.size() == 0) cmp_val(16'h0001, 16'h0000, 16'hffff);
			else begin
				pe = pq.pop_front();
				cmp_pix(pe);
			end
		end
	end
	// Watchdog
	initial begin
		#(60000 * 50);
		bad_count = bad_count + 1;
		finish_test;
	end
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, frame_start, frame_end, pix_valid, pix_line_end} = 7'h00;
		{pix_first_exposure, ctx_exp, ctx_cfg, reg_addr, reg_wdata, pix_data} = 0;
		ce = 1'b1;
		calib_hot_value = 16'h5a3c;
		calib_warm_value = 16'h1e77;
		for (i = 0; i < 256; i = i + 1) begin
			live[i] = (i == 8'h32) ? `RST_EMB_CONTROL : 16'h0000;
			pend[i] = live[i];
		end
		k = $urandom(73741);
		temp_adc_value = $urandom;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`OFS_EMB_CONTROL, `RST_EMB_CONTROL, 16'hffff);
		rd(`OFS_COMPAND_EN, 16'h0000, 16'hffff);
		rd(16'h3130, 16'h0000, 16'hffff);
		wr(`OFS_CALIB_HOT, 16'h0000);
		rd(`OFS_CALIB_HOT, calib_hot_value, 16'hffff);
		rd(`OFS_CALIB_WARM, calib_warm_value, 16'hffff);
		wr(`OFS_TEMP_CTRL, 16'h0001);
		@(negedge mclk);
		cmp_val({15'h0, temp_sense_enable}, 16'h0000, 16'hffff);
		wr(`OFS_TEMP_CTRL, 16'h0011);
		@(negedge mclk);
		cmp_val({15'h0, temp_sense_enable}, 16'h0001, 16'hffff);
		repeat (4) @(posedge mclk);
		rd(`OFS_TEMP_RESULT, {6'h00, temp_adc_value}, 16'h03ff);
		for (i = 0; i < 32; i = i + 1) begin
			k = $urandom;
			wr({7'h18, rw_list[8 * i +: 8], 1'b0}, k[15:0]);
			rd({7'h18, rw_list[8 * i +: 8], 1'b0}, k[15:0], 16'hffff);
		end
		// Frozen clock enable: a write must not land
		@(posedge mclk);
		ce <= 1'b0;
		k = live[8'he9];
		wr(`OFS_FRAME_IDENTIFIER, ~k[15:0]);
		live[8'he9] = k[15:0];
		ce <= 1'b1;
		rd(`OFS_FRAME_IDENTIFIER, k[15:0], 16'hffff);
		frame(2);
		wr(`OFS_EMB_CONTROL, 16'h0180);
		wr(`OFS_COMPAND_EN, 16'h0001);
		wr(`OFS_CONTEXT_CTRL, 16'h2000);
		repeat (3) frame(2);
		wr(`OFS_CONTEXT_CTRL, 16'h0000);
		wr(`OFS_OPCTRL_A, 16'h0001);
		frame(2);
		wr(`OFS_SEQ_CTRL, 16'h0100);
		repeat (3) frame(2);
		wr(`OFS_OPCTRL_A, 16'h0000);
		repeat (3) frame(2);
		wr(`OFS_EMB_CONTROL, 16'h0000);
		repeat (2) frame(1);
		cmp_val(row_count, rows_exp[15:0], 16'hffff);
		cmp_val(pq.size(), 16'h0000, 16'hffff);
		finish_test;
	end
endmodule
